// ==== verilog/llm_pkg.sv ====
package llm_pkg;

	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [4:0] REG_SETUP_IDX = 5'h16;
	localparam logic [4:0] REG_STATUS_IDX = 5'h17;
	localparam logic [4:0] REG_COUNT_LO_IDX = 5'h18;
	localparam logic [15:0] SETUP_RESET = 16'h7F00;

	// ----------------------------------------
	// Setup field positions
	// ----------------------------------------
	localparam int START_SEL_BIT = 7;
	localparam int STOP_SEL_BIT = 6;
	localparam int DIV_LSB = 4;
	localparam int CLK_SRC_BIT = 2;
	localparam int ENABLE_BIT = 1;
	localparam int CHAN_SEL_BIT = 0;

	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int START_FLAG_LSB = 12;
	localparam int STOP_FLAG_LSB = 8;
	localparam int DONE_BIT = 4;

	localparam int COUNT_W = 20;
	localparam logic [19:0] COUNT_MAX = 20'hFFFFF;
	localparam logic [19:0] COUNT_ZERO = 20'h00000;
	localparam logic [2:0] DIV_RESET = 3'h0;

	typedef enum logic [1:0] {
		LLM_IDLE,
		LLM_COUNT,
		LLM_DONE
	} llm_state_t;

endpackage : llm_pkg

// ==== verilog/llm_tick_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

// Produces one-cycle count ticks: recovered byte clock strobe, or divided
// measurement clock (divide by 1, 2, 4 or 8).
module llm_tick_gen (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_src_sel,
	input wire logic [1:0] div_code,
	input wire logic byte_clk_stb,
	output logic tick
);

	logic [2:0] div_ff;
	logic [2:0] nxt_div;
	logic [2:0] div_mask;
	logic div_wrap;

	assign div_mask = (3'h1 << div_code) - 3'h1;
	assign div_wrap = (div_ff & div_mask) == div_mask;
	assign nxt_div = div_wrap ? llm_pkg::DIV_RESET : div_ff + 3'h1;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_ff <= llm_pkg::DIV_RESET;
		end else begin
			div_ff <= nxt_div;
		end
	end

	// Source 1 counts on recovered byte clock strobes; source 0 on divider wraps
	assign tick = clk_src_sel ? byte_clk_stb : div_wrap;

endmodule : llm_tick_gen

`default_nettype wire

// ==== verilog/llm_latency_meas.sv ====
`timescale 1ns/1ps
`default_nettype none

module llm_latency_meas (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [3:0] low_speed_transmit_input_comma_a,
	input wire logic [3:0] low_speed_transmit_input_comma_b,
	input wire logic [1:0] high_speed_receive_input_comma_a,
	input wire logic [1:0] high_speed_receive_input_comma_b,
	input wire logic [3:0] low_speed_receive_output_comma_a,
	input wire logic [3:0] low_speed_receive_output_comma_b,
	input wire logic [1:0] high_speed_transmit_output_comma_a,
	input wire logic [1:0] high_speed_transmit_output_comma_b,
	input wire logic byte_clk_stb_a,
	input wire logic byte_clk_stb_b
);

	// ----------------------------------------
	// Register access decode
	// ----------------------------------------
	logic [15:0] setup_ff;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic wr_setup;
	logic rd_count_lo;

	assign wr_setup = reg_wr && (reg_addr == llm_pkg::REG_SETUP_IDX);
	assign rd_count_lo = reg_rd && (reg_addr == llm_pkg::REG_COUNT_LO_IDX);

	wire start_sel = setup_ff[llm_pkg::START_SEL_BIT];
	wire stop_sel = setup_ff[llm_pkg::STOP_SEL_BIT];
	wire clk_src = setup_ff[llm_pkg::CLK_SRC_BIT];
	wire meas_en = setup_ff[llm_pkg::ENABLE_BIT];
	wire chan_sel = setup_ff[llm_pkg::CHAN_SEL_BIT];
	wire [1:0] div_code = setup_ff[llm_pkg::DIV_LSB +: 2];

	// ----------------------------------------
	// Comma source selection
	// ----------------------------------------
	wire [3:0] low_speed_transmit_input_sel = chan_sel ? low_speed_transmit_input_comma_b : low_speed_transmit_input_comma_a;
	wire [1:0] high_speed_receive_input_sel = chan_sel ? high_speed_receive_input_comma_b : high_speed_receive_input_comma_a;
	wire [3:0] low_speed_receive_output_sel = chan_sel ? low_speed_receive_output_comma_b : low_speed_receive_output_comma_a;
	wire [1:0] high_speed_transmit_output_sel = chan_sel ? high_speed_transmit_output_comma_b : high_speed_transmit_output_comma_a;
	wire byte_stb = chan_sel ? byte_clk_stb_b : byte_clk_stb_a;

	// High-speed points use only flag bits 1:0; 3:2 stay zero
	wire [3:0] start_commas = start_sel ? {2'h0, high_speed_receive_input_sel} : low_speed_transmit_input_sel;
	wire [3:0] stop_commas = stop_sel ? {2'h0, high_speed_transmit_output_sel} : low_speed_receive_output_sel;

	// ----------------------------------------
	// Measurement engine
	// ----------------------------------------
	llm_pkg::llm_state_t state_ff;
	llm_pkg::llm_state_t nxt_state;
	logic [19:0] count_ff;
	logic [19:0] nxt_count;
	logic [3:0] start_flag_ff;
	logic [3:0] stop_flag_ff;
	logic done_ff;
	logic tick;

	// Count ticks: divided internal clock, or the recovered byte clock strobe
	llm_tick_gen u_tick (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clk_src_sel(clk_src),
		.div_code(div_code),
		.byte_clk_stb(byte_stb),
		.tick(tick)
	);

	wire start_hit = meas_en && (state_ff == llm_pkg::LLM_IDLE) && (|start_commas);
	wire stop_hit = (state_ff == llm_pkg::LLM_COUNT) && (|stop_commas);
	wire at_max = (count_ff == llm_pkg::COUNT_MAX);

	// ----------------------------------------
	// State and counter next values
	// ----------------------------------------
	// Holding at the top keeps an overlong interval readable as all ones
	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		unique case (state_ff)
			llm_pkg::LLM_IDLE: begin
				if (start_hit) begin
					nxt_state = llm_pkg::LLM_COUNT;
				end
			end
			llm_pkg::LLM_COUNT: begin
				if (!meas_en) begin
					// Abandon an open interval; no partial result is reported
					nxt_state = llm_pkg::LLM_IDLE;
					nxt_count = llm_pkg::COUNT_ZERO;
				end else begin
					if (tick && !at_max) begin
						nxt_count = count_ff + 20'h00001;
					end
					if (stop_hit) begin
						nxt_state = llm_pkg::LLM_DONE;
					end
				end
			end
			llm_pkg::LLM_DONE: begin
				nxt_state = llm_pkg::LLM_DONE;
			end
			default: begin
				nxt_state = llm_pkg::LLM_IDLE;
			end
		endcase
		if (rd_count_lo) begin
			nxt_state = llm_pkg::LLM_IDLE;
			nxt_count = llm_pkg::COUNT_ZERO;
		end
	end

	// ----------------------------------------
	// Status word and read data
	// ----------------------------------------
	// Status layout: start flags, stop flags, gap, done, count bits 19:16
	// Count reads zero until stop comma completes it
	wire [19:0] shown_count = done_ff ? count_ff : llm_pkg::COUNT_ZERO;

	wire [15:0] status_word = {start_flag_ff, stop_flag_ff, 3'h0, done_ff,
		shown_count[19:16]};

	always_comb begin
		nxt_rdata = 16'h0000;
		if (reg_addr == llm_pkg::REG_SETUP_IDX) begin
			nxt_rdata = setup_ff;
		end else if (reg_addr == llm_pkg::REG_STATUS_IDX) begin
			nxt_rdata = status_word;
		end else if (reg_addr == llm_pkg::REG_COUNT_LO_IDX) begin
			nxt_rdata = shown_count[15:0];
		end
	end

	// ----------------------------------------
	// Setup register
	// ----------------------------------------
	// Upper bits are kept as written, so software reads back its own value
	// Writes to the status and count indices have no effect
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			setup_ff <= llm_pkg::SETUP_RESET;
		end else if (wr_setup) begin
			setup_ff <= reg_wdata;
		end
	end

	// ----------------------------------------
	// State and counter registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= llm_pkg::LLM_IDLE;
			count_ff <= llm_pkg::COUNT_ZERO;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
		end
	end

	// ----------------------------------------
	// Comma flags and done flag
	// ----------------------------------------
	// Flags: a comma in the same cycle as the clearing read still sets them, except in LLM_DONE
	// Start commas after the count has stopped are ignored, so a finished
	// result keeps the flags it was taken with
	wire start_window = start_hit || (state_ff == llm_pkg::LLM_COUNT);
	wire [3:0] start_set = (start_window && meas_en) ? start_commas : 4'h0;
	wire stop_done = stop_hit && meas_en;
	wire [3:0] stop_set = stop_done ? stop_commas : 4'h0;
	// A stop comma in the clearing cycle is lost together with its count
	wire done_set = stop_done && !rd_count_lo;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			start_flag_ff <= 4'h0;
			stop_flag_ff <= 4'h0;
			done_ff <= 1'b0;
		end else begin
			start_flag_ff <= (rd_count_lo ? 4'h0 : start_flag_ff) | start_set;
			stop_flag_ff <= (rd_count_lo ? 4'h0 : stop_flag_ff) | stop_set;
			done_ff <= (done_ff && !rd_count_lo) || done_set;
		end
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	// Registered so the bus output leaves a flop; a read answers one cycle later
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule : llm_latency_meas

`default_nettype wire

// ==== verification/llm_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module llm_checker (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [3:0] low_speed_transmit_input_comma_a,
	input wire logic [3:0] low_speed_transmit_input_comma_b,
	input wire logic [1:0] high_speed_receive_input_comma_a,
	input wire logic [1:0] high_speed_receive_input_comma_b,
	input wire logic [3:0] low_speed_receive_output_comma_a,
	input wire logic [3:0] low_speed_receive_output_comma_b,
	input wire logic [1:0] high_speed_transmit_output_comma_a,
	input wire logic [1:0] high_speed_transmit_output_comma_b
);
	localparam logic [4:0] SU = llm_pkg::REG_SETUP_IDX;
	localparam logic [4:0] ST = llm_pkg::REG_STATUS_IDX;
	localparam logic [4:0] LO = llm_pkg::REG_COUNT_LO_IDX;
	// A comma in the clearing cycle may set flags again, so clears are judged only when quiet
	wire logic quiet = ~|{low_speed_transmit_input_comma_a, low_speed_transmit_input_comma_b, high_speed_receive_input_comma_a, high_speed_receive_input_comma_b,
		low_speed_receive_output_comma_a, low_speed_receive_output_comma_b, high_speed_transmit_output_comma_a, high_speed_transmit_output_comma_b};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_unmapped_zero: assert property ((reg_addr < SU || reg_addr > LO) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_setup_write: assert property (reg_wr && reg_addr == SU ##1 reg_addr == SU && !reg_wr
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("setup write lost");
	a_setup_hold: assert property ((reg_addr == SU && !reg_wr) [*3] |-> $stable(reg_rdata))
		else $error("setup changed unwritten");
	a_clear_status: assert property (reg_rd && reg_addr == LO && quiet ##1 quiet
		##1 reg_addr == ST && quiet |=> reg_rdata == 16'h0000) else $error("status not cleared");
	a_clear_count: assert property (reg_rd && reg_addr == LO && quiet ##1 reg_addr == LO
		|=> reg_rdata == 16'h0000) else $error("count not cleared");
	a_status_gap: assert property (reg_addr == ST |=> reg_rdata[7:5] == 3'h0)
		else $error("status gap bits set");
	a_count_until_done: assert property (reg_addr == ST ##1 !reg_rdata[4] |-> reg_rdata[3:0] == 4'h0)
		else $error("count shown before done");
	a_done_hold: assert property (reg_addr == ST && !reg_wr && !reg_rd ##1 reg_addr == ST
		&& reg_rdata[4] && !reg_wr && !reg_rd |=> reg_rdata[4]) else $error("done dropped");
	c_done: cover property (reg_addr == ST ##1 reg_rdata[4]);
	c_clear: cover property (reg_rd && reg_addr == LO);
	c_write: cover property (reg_wr && reg_addr == SU);
endmodule : llm_checker
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [23:0] cm = 24'h000000;
	logic [1:0] stb = 2'h0;
	logic [1:0] ph = 2'h0;
	logic [15:0] d;
	logic [15:0] st;
	logic [19:0] c;
	int num_errors = 0;
	int compares = 0;
	logic [15:0] cfg [9] = '{16'h7F02, 16'h7FC2, 16'h7FC3, 16'h7F03, 16'h7F12,
		16'h7F22, 16'h7F32, 16'h7F06, 16'h7F03};
	int si [9] = '{2, 9, 10, 4, 0, 0, 0, 0, 0};
	int pi [9] = '{13, 20, 23, 19, 12, 12, 12, 12, 12};
	logic [7:0] fb [9] = '{8'h42, 8'h21, 8'h12, 8'h18, 8'h11, 8'h11, 8'h11, 8'h11, 8'h00};
	int n [9] = '{101, 101, 101, 101, 50, 25, 12, 25, 0};
	int tol [9] = '{0, 0, 0, 0, 1, 1, 1, 1, 0};
	llm_latency_meas dut (.ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.low_speed_transmit_input_comma_a(cm[3:0]), .low_speed_transmit_input_comma_b(cm[7:4]), .high_speed_receive_input_comma_a(cm[9:8]),
		.high_speed_receive_input_comma_b(cm[11:10]), .low_speed_receive_output_comma_a(cm[15:12]), .low_speed_receive_output_comma_b(cm[19:16]),
		.high_speed_transmit_output_comma_a(cm[21:20]), .high_speed_transmit_output_comma_b(cm[23:22]), .byte_clk_stb_a(stb[0]),
		.byte_clk_stb_b(stb[1]));
	initial forever #25 ref_clk = ~ref_clk;
	// Byte clock strobes: A one cycle in four, B one in two, so a wrong pick shows
	always @(posedge ref_clk) begin
		ph <= #1 ph + 2'h1;
		stb <= #1 {ph[0], ph == 2'h3};
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] v);
		@(posedge ref_clk) #1;
		reg_addr = llm_pkg::REG_SETUP_IDX;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge ref_clk) #1;
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic clr);
		@(posedge ref_clk) #1;
		reg_addr = a;
		reg_rd = clr;
		@(posedge ref_clk) #1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
	// One start comma, 100 idle cycles, one stop comma, then a status read
	task automatic meas(input int s, input int p);
		@(posedge ref_clk) #1;
		cm = 24'h000001 << s;
		@(posedge ref_clk) #1;
		cm = 24'h000000;
		repeat (100) @(posedge ref_clk);
		#1 cm = 24'h000001 << p;
		@(posedge ref_clk) #1;
		cm = 24'h000000;
		rd(llm_pkg::REG_STATUS_IDX, 1'b0);
	endtask : meas
	task automatic end_of_test();
		$display("num_errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		rd(llm_pkg::REG_SETUP_IDX, 1'b0);
		chk(d, llm_pkg::SETUP_RESET);
		rd(5'h1F, 1'b0);
		chk(d, 16'h0000);
		meas(0, 12);
		chk(d, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			wr(cfg[i]);
			rd(llm_pkg::REG_SETUP_IDX, 1'b0);
			chk(d, cfg[i]);
			meas(si[i], pi[i]);
			st = d;
			chk(d, (n[i] == 0) ? 16'h0000 : {fb[i], 8'h10});
			rd(llm_pkg::REG_COUNT_LO_IDX, 1'b1);
			c = {st[3:0], d};
			// Divider and strobe phase leave one tick of slack; divide by one is exact
			chk({15'h0, c + tol[i] >= n[i] && c <= n[i] + tol[i] && (n[i] > 0 || c == 0)}, 16'h0001);
			rd(llm_pkg::REG_STATUS_IDX, 1'b0);
			chk(d, 16'h0000);
			rd(llm_pkg::REG_COUNT_LO_IDX, 1'b0);
			chk(d, 16'h0000);
		end
		end_of_test();
	end
endmodule : tb
bind llm_latency_meas llm_checker chk_i (.ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata, .low_speed_transmit_input_comma_a, .low_speed_transmit_input_comma_b, .high_speed_receive_input_comma_a, .high_speed_receive_input_comma_b,
	.low_speed_receive_output_comma_a, .low_speed_receive_output_comma_b, .high_speed_transmit_output_comma_a, .high_speed_transmit_output_comma_b);
`default_nettype wire
